// >>> rtl/fcc_pkg.sv
// Constants for the serial frame CRC generator and checker.
// Assumes 32-bit frames, most significant frame bit first on the serial link.
package fcc_pkg;
   // Generator polynomial x8+x5+x3+x2+x+1 without the x8 term
   localparam logic [7:0] FCC_POLY = 8'h2F;
   localparam logic [7:0] FCC_CRC_RST = 8'h00;
   // Frame and payload lengths in bits
   localparam logic [5:0] FCC_FRAME_BITS = 6'd32;
   localparam logic [5:0] FCC_WR_PAY_BITS = 6'd21;
   localparam logic [5:0] FCC_RD_PAY_BITS = 6'd22;
   // Last frame-bit count at which a CRC bit is still shifted out
   localparam logic [5:0] FCC_RD_CRC_LAST = 6'd29;
   // Write frame field positions
   localparam int FCC_WR_DEV_HI = 31;
   localparam int FCC_WR_DEV_LO = 27;
   localparam int FCC_WR_REG_HI = 26;
   localparam int FCC_WR_REG_LO = 21;
   localparam int FCC_WR_DAT_HI = 20;
   localparam int FCC_WR_DAT_LO = 13;
   localparam int FCC_WR_ALL_BIT = 12;
   localparam int FCC_WR_CRC_HI = 10;
   localparam int FCC_WR_CRC_LO = 3;
   // Readback frame: payload above the acknowledge bit, padding below
   localparam int FCC_RD_USER_BITS = 21;
   localparam int FCC_RD_PAD_BITS = 10;
endpackage

// >>> rtl/fcc_crc_step.sv
// Bit-serial CRC-8 shift register, one payload bit per enabled clock.
// Assumes clear and step come from logic on the same clock.
`timescale 1ns/1ps
module fcc_crc_step
   import fcc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Control
   input wire logic clr,
   input wire logic step,
   input wire logic din,
   // Result
   output logic [7:0] crc_q
);
   logic [7:0] base;
   logic [7:0] crc_d;
   logic fb;

   // A clear in the same cycle as a step starts the new frame from zero
   always_comb
   begin
      base = clr ? FCC_CRC_RST : crc_q;
      fb = base[7];
      crc_d = {base[6:0], din} ^ ({8{fb}} & FCC_POLY);
      if (!step)
      begin
         crc_d = base;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         crc_q <= FCC_CRC_RST;
      end
      else
      begin
         crc_q <= crc_d;
      end
   end

   property p_step_eq;
      @(posedge clk) disable iff (srst)
      (step && !clr) |=> (crc_q == (({$past(crc_q[6:0]), $past(din)})
                                     ^ ({8{$past(crc_q[7])}} & FCC_POLY)));
   endproperty
   a_step_eq: assert property (p_step_eq) else $error("crc step wrong");

   property p_clr_zero;
      @(posedge clk) disable iff (srst)
      (clr && !step) |=> (crc_q == FCC_CRC_RST);
   endproperty
   a_clr_zero: assert property (p_clr_zero) else $error("crc not cleared");
endmodule

// >>> rtl/fcc_frame_crc.sv
// Serial frame CRC unit: checks write frames and builds readback frames.
// Assumes serial pins are asynchronous to clk and slow enough to be sampled.
//
// Overview of operation
// - Each readback frame carries a CRC over bits 31..10 in its bits 9..2.
// - For conversion readback the CRC covers address, channel, result and acknowledge bit.
// - For register readback the CRC covers address, register, contents, two zeros and ack.
// - The CRC is the 8-bit remainder of division by x8+x5+x3+x2+x+1, sent bit 7 first.
// - The payload is 21 bits for a write frame and 22 bits for a readback frame.
// - Write payload is bits 31..11, readback payload bits 31..10, highest bit first.
// - The CRC state is cleared to zero before every frame.
// - Each step shifts the state left, feeding in^bit7 and folding bit7 into taps 1,2,3,5.
// - A write whose received CRC differs from the computed one is discarded.
// - The acknowledge bit of the next readback frame is set only after an accepted write.
`timescale 1ns/1ps
module fcc_frame_crc
   import fcc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Serial link pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo_q,
   // Readback payload, bits 31..11, sampled at frame start
   input wire logic [20:0] rd_payload,
   // Accepted write
   output logic wr_stb_q,
   output logic [4:0] wr_dev_q,
   output logic [5:0] wr_reg_q,
   output logic [7:0] wr_data_q,
   output logic wr_all_q,
   // Status
   output logic crc_err_q,
   output logic ack_q
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic ck_s1_q, ck_s2_q, ck_s3_q;
   logic di_s1_q, di_s2_q;
   logic cs_fall, cs_rise, ck_rise, ck_fall, active;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         di_s1_q <= 1'b0;
         di_s2_q <= 1'b0;
      end
      else
      begin
         cs_s1_q <= cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         ck_s1_q <= sclk;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         di_s1_q <= sdi;
         di_s2_q <= di_s1_q;
      end
   end

   assign cs_fall = cs_s3_q && !cs_s2_q;
   assign cs_rise = !cs_s3_q && cs_s2_q;
   assign active = !cs_s2_q;
   assign ck_rise = active && ck_s2_q && !ck_s3_q;
   assign ck_fall = active && !ck_s2_q && ck_s3_q;

   ////////////////////////////////////////////////////////////////////////////
   // Receive side: shift in write frame, check its CRC
   logic [31:0] rx_sh_q;
   logic [5:0] rx_cnt_q;
   logic [7:0] rx_crc;
   logic rx_step, rx_good, rx_full;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rx_sh_q <= 32'h0000_0000;
         rx_cnt_q <= 6'd0;
      end
      else if (cs_fall)
      begin
         rx_cnt_q <= 6'd0;
      end
      else if (ck_rise)
      begin
         rx_sh_q <= {rx_sh_q[30:0], di_s2_q};
         if (rx_cnt_q != FCC_FRAME_BITS)
         begin
            rx_cnt_q <= rx_cnt_q + 6'd1;
         end
      end
   end

   // Only the first 21 received bits enter the checker
   assign rx_step = ck_rise && (rx_cnt_q < FCC_WR_PAY_BITS);

   fcc_crc_step u_rx_crc (
      .clk(clk),
      .srst(srst),
      .clr(cs_fall),
      .step(rx_step),
      .din(di_s2_q),
      .crc_q(rx_crc)
   );

   assign rx_full = (rx_cnt_q == FCC_FRAME_BITS);
   assign rx_good = rx_full && (rx_sh_q[FCC_WR_CRC_HI:FCC_WR_CRC_LO] == rx_crc);

   // A short frame, or a pure readback frame with idle input, also clears ack
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wr_stb_q <= 1'b0;
         crc_err_q <= 1'b0;
         ack_q <= 1'b0;
         wr_dev_q <= 5'h00;
         wr_reg_q <= 6'h00;
         wr_data_q <= 8'h00;
         wr_all_q <= 1'b0;
      end
      else
      begin
         wr_stb_q <= cs_rise && rx_good;
         crc_err_q <= cs_rise && rx_full && !rx_good;
         if (cs_rise)
         begin
            ack_q <= rx_good;
         end
         if (cs_rise && rx_good)
         begin
            wr_dev_q <= rx_sh_q[FCC_WR_DEV_HI:FCC_WR_DEV_LO];
            wr_reg_q <= rx_sh_q[FCC_WR_REG_HI:FCC_WR_REG_LO];
            wr_data_q <= rx_sh_q[FCC_WR_DAT_HI:FCC_WR_DAT_LO];
            wr_all_q <= rx_sh_q[FCC_WR_ALL_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit side: readback payload plus ack, then CRC, then zeros
   logic [31:0] tx_sh_q;
   logic [5:0] tx_cnt_q;
   logic [7:0] tx_crc;
   logic [5:0] crc_off;
   logic tx_step, tx_din, next_bit;

   // Payload layout of address, channel or register and data is the caller's
   assign tx_din = cs_fall ? rd_payload[FCC_RD_USER_BITS-1] : tx_sh_q[30];
   assign tx_step = cs_fall || (ck_fall && (tx_cnt_q < FCC_RD_PAY_BITS));
   assign crc_off = FCC_RD_CRC_LAST - tx_cnt_q;

   fcc_crc_step u_tx_crc (
      .clk(clk),
      .srst(srst),
      .clr(cs_fall),
      .step(tx_step),
      .din(tx_din),
      .crc_q(tx_crc)
   );

   always_comb
   begin
      next_bit = 1'b0;
      if (tx_cnt_q < FCC_RD_PAY_BITS)
      begin
         next_bit = tx_sh_q[30];
      end
      else if (tx_cnt_q <= FCC_RD_CRC_LAST)
      begin
         next_bit = tx_crc[crc_off[2:0]];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_sh_q <= 32'h0000_0000;
         tx_cnt_q <= 6'd0;
         sdo_q <= 1'b0;
      end
      else if (cs_fall)
      begin
         tx_sh_q <= {rd_payload, ack_q, {FCC_RD_PAD_BITS{1'b0}}};
         tx_cnt_q <= 6'd1;
         sdo_q <= rd_payload[FCC_RD_USER_BITS-1];
      end
      else if (ck_fall)
      begin
         tx_sh_q <= {tx_sh_q[30:0], 1'b0};
         sdo_q <= next_bit;
         if (tx_cnt_q != FCC_FRAME_BITS)
         begin
            tx_cnt_q <= tx_cnt_q + 6'd1;
         end
      end
      else if (cs_rise)
      begin
         sdo_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   logic [5:0] rx_steps_q, tx_steps_q;

   always_ff @(posedge clk)
   begin
      if (srst || cs_fall)
      begin
         rx_steps_q <= 6'd0;
      end
      else if (rx_step)
      begin
         rx_steps_q <= rx_steps_q + 6'd1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_steps_q <= 6'd0;
      end
      else if (cs_fall)
      begin
         tx_steps_q <= 6'd1;
      end
      else if (tx_step)
      begin
         tx_steps_q <= tx_steps_q + 6'd1;
      end
   end

   property p_bad_drop;
      @(posedge clk) disable iff (srst)
      (cs_rise && !rx_good) |=> !wr_stb_q;
   endproperty
   a_bad_drop: assert property (p_bad_drop) else $error("bad write taken");

   property p_good_take;
      @(posedge clk) disable iff (srst)
      (cs_rise && rx_good) |=> (wr_stb_q && ack_q
         && wr_reg_q == $past(rx_sh_q[FCC_WR_REG_HI:FCC_WR_REG_LO]));
   endproperty
   a_good_take: assert property (p_good_take) else $error("good write lost");

   property p_ack_only_good;
      @(posedge clk) disable iff (srst)
      $rose(ack_q) |-> $past(cs_rise && rx_good);
   endproperty
   a_ack_only_good: assert property (p_ack_only_good) else $error("ack without write");

   property p_rx_len;
      @(posedge clk) disable iff (srst)
      (rx_cnt_q >= FCC_WR_PAY_BITS) |-> (rx_steps_q == FCC_WR_PAY_BITS);
   endproperty
   a_rx_len: assert property (p_rx_len) else $error("write crc length");

   property p_tx_len;
      @(posedge clk) disable iff (srst)
      (active && tx_cnt_q >= FCC_RD_PAY_BITS) |-> (tx_steps_q == FCC_RD_PAY_BITS);
   endproperty
   a_tx_len: assert property (p_tx_len) else $error("read crc length");

   property p_crc_msb;
      @(posedge clk) disable iff (srst)
      (ck_fall && tx_cnt_q == FCC_RD_PAY_BITS) |=> (sdo_q == $past(tx_crc[7]));
   endproperty
   a_crc_msb: assert property (p_crc_msb) else $error("crc msb not sent");

   property p_load;
      @(posedge clk) disable iff (srst)
      cs_fall |=> (tx_sh_q[31:10] == {$past(rd_payload), $past(ack_q)} && sdo_q == tx_sh_q[31]);
   endproperty
   a_load: assert property (p_load) else $error("readback load wrong");

   property p_tail_zero;
      @(posedge clk) disable iff (srst)
      (ck_fall && tx_cnt_q > FCC_RD_CRC_LAST) |=> !sdo_q;
   endproperty
   a_tail_zero: assert property (p_tail_zero) else $error("tail not zero");

   c_good_write: cover property (@(posedge clk) disable iff (srst) wr_stb_q);
   c_bad_write: cover property (@(posedge clk) disable iff (srst) crc_err_q);
   c_full_read: cover property (@(posedge clk) disable iff (srst)
      (cs_rise && tx_cnt_q == FCC_FRAME_BITS));
endmodule

// >>> test/fcc_host_model.sv
// Host-side serial master that sends frames to the frame CRC unit.
// Assumes the caller spaces frames; one link bit takes 64 ns.
`timescale 1ns/1ps
module fcc_host_model
(
   // Serial link pins
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sends the top n bits of tx and captures sdo just before each falling edge
   task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0000_0000;
      #3 cs_n = 1'b0;
      #37;
      for (int i = 31; i >= 32 - n; i--)
      begin
         sdi = tx[i];
         #32 sclk = 1'b1;
         #31 rx[i] = sdo;
         #1 sclk = 1'b0;
      end
      #32 cs_n = 1'b1;
      // Released line must not keep looking valid
      sdi = ~sdi;
      #64;
   endtask
endmodule

// >>> test/fcc_frame_crc_tb.sv
// Self-checking bench for the serial frame CRC unit.
// Assumes the host model drives the link; expectations come from bench functions.
`timescale 1ns/1ps
module fcc_frame_crc_tb;
   logic clk, srst, cs_n, sclk, sdi, sdo_q, wr_stb_q, wr_all_q, crc_err_q, ack_q, ack_e;
   logic [20:0] rd_payload;
   logic [4:0] wr_dev_q;
   logic [5:0] wr_reg_q;
   logic [7:0] wr_data_q;
   logic [31:0] seed, tx, rx, last_w;
   int n_mismatch, checked, n_stb, n_err;

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   fcc_frame_crc i_fcc_frame_crc (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
      .sdi(sdi), .sdo_q(sdo_q), .rd_payload(rd_payload), .wr_stb_q(wr_stb_q),
      .wr_dev_q(wr_dev_q), .wr_reg_q(wr_reg_q), .wr_data_q(wr_data_q),
      .wr_all_q(wr_all_q), .crc_err_q(crc_err_q), .ack_q(ack_q));

   fcc_host_model i_fcc_host_model (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_q));

   always @(posedge clk)
   begin
      if (wr_stb_q === 1'b1) n_stb++;
      if (crc_err_q === 1'b1) n_err++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Fresh shift register per call, highest payload bit first
   function automatic logic [7:0] crc8(input logic [21:0] d, input int n);
      logic [7:0] c;
      logic f;
      c = 8'h00;
      for (int i = n - 1; i >= 0; i--)
      begin
         f = c[7];
         c = {c[6:5], c[4] ^ f, c[3], c[2] ^ f, c[1] ^ f, c[0] ^ f, d[i] ^ f};
      end
      return c;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // About 2.2 us per frame; generous margin for 40 frames
   initial
   begin
      #300000;
      n_mismatch++;
      stop_test();
   end

   initial
   begin
      seed = 32'heddd_4056;
      srst = 1'b1;
      rd_payload = 21'h00_0000;
      n_mismatch = 0;
      checked = 0;
      n_stb = 0;
      n_err = 0;
      last_w = 32'h0000_0000;
      ack_e = 1'b0;
      repeat (20) @(posedge clk);
      #1 srst = 1'b0;
      chk("ack_q", 32'h0000_0000, ack_q);
      chk("sdo_q", 32'h0000_0000, sdo_q);
      for (int k = 0; k < 40; k++)
      begin
         logic [31:0] r, e;
         logic [20:0] p;
         logic bad, good;
         int n, s0, e0;
         @(posedge clk);
         #1;
         r = xs();
         p = r[20:0];
         p[0] = 1'b0;
         if (p[1]) p[20:16] = 5'h00;
         // Corrupt about a quarter of frames from the fourth on; frame 3 is one bit short
         bad = (r[31:30] == 2'b11) && (k > 2);
         n = (k == 3) ? 31 : 32;
         tx = {p, crc8({1'b0, p}, 21) ^ ({7'h00, bad} << r[24:22]), 3'b000};
         if (k == 0) tx = 32'h89A1_84E8;
         r = xs();
         rd_payload <= (k == 1) ? 21'h00_3850 : (k == 2) ? 21'h10_299A : r[20:0];
         #1;
         e = {rd_payload, ack_e, crc8({rd_payload, ack_e}, 22), 2'b00};
         s0 = n_stb;
         e0 = n_err;
         i_fcc_host_model.frame(tx, n, rx);
         repeat (2) @(posedge clk);
         #1;
         good = (n == 32) && !bad;
         chk("rx", e, rx);
         if (k == 1) chk("rx", 32'h01C2_8668, rx);
         if (k == 2) chk("rx", 32'h814C_D518, rx);
         chk("wr_stb", good, n_stb - s0);
         chk("crc_err", (n == 32) && bad, n_err - e0);
         if (good) last_w = tx;
         chk("fields", last_w[31:12], {wr_dev_q, wr_reg_q, wr_data_q, wr_all_q});
         chk("ack_q", good, ack_q);
         ack_e = good;
      end
      stop_test();
   end
endmodule
